/* File: hw/hv_indirect_defines.svh */
`ifndef HV_INDIRECT_DEFINES_SVH
`define HV_INDIRECT_DEFINES_SVH

// processor map
`define HV_CMD_ADDR 32'hffff0804
`define HV_DAT_ADDR 32'hffff080c

// command codes
`define HV_CMD_RD_CFG0 8'h00
`define HV_CMD_RD_CFG1 8'h01
`define HV_CMD_RD_STA 8'h02
`define HV_CMD_RD_MON 8'h03
`define HV_CMD_WR_CFG0 8'h08
`define HV_CMD_WR_CFG1 8'h09

// command register read fields
`define HV_CMD_BUSY_BIT 0
`define HV_CMD_RDOK_BIT 1
`define HV_CMD_TXOK_BIT 2

// data register fields
`define HV_DAT_TAG_MSB 11
`define HV_DAT_TAG_LSB 8
`define HV_DAT_VAL_MSB 7
`define HV_DAT_VAL_LSB 0

// config zero fields and reset
`define HV_CFG_RESET 8'h00
`define HV_CFG0_TSD_DIS_BIT 7
`define HV_CFG0_OSC_EN_BIT 6
`define HV_CFG0_BSD_BIT 5
`define HV_CFG0_WAKE_BIT 4
`define HV_CFG0_PSM_EN_BIT 3
`define HV_CFG0_LVF_EN_BIT 2
`define HV_CFG0_LIN_MSB 1
`define HV_CFG0_LIN_LSB 0
`define HV_LIN_OFF 2'b00
`define HV_LIN_ON 2'b10
`define HV_MON_LVF_BIT 3

// timing
`define HV_SYS_CLK_MHZ 100
`define HV_LATENCY_US 10
`define HV_LATENCY_CYC (`HV_LATENCY_US * `HV_SYS_CLK_MHZ)
`define HV_LINK_BITS 16

`endif

/* File: hw/hv_indirect_pkg.sv */
package hv_indirect_pkg;

    typedef struct packed {
        logic [31:0] addr;
        logic wr;
        logic rd;
        logic [31:0] wdata;
    } mmr_req_t;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] data;
    } hv_req_t;

    typedef struct packed {
        logic [3:0] tag;
        logic [7:0] data;
        logic rd_ok;
        logic tx_ok;
    } hv_rsp_t;

    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_SHIFT,
        LINK_EXEC
    } link_state_t;

endpackage

/* File: hw/hv_indirect_data_and_config.sv */
// What this block does
// - 12-bit data window register, read and written by the processor
// - bits 11..8 are a read-only command tag; software writes zeros there
// - commands 0x00..0x03 read config zero, config one, status, monitor
// - 0x08 writes config zero, 0x09 writes config one, from low byte
// - bits 7..0 hold the byte moved in either direction
// - config zero is 8 bits, resets to 0x00, reached only indirectly
// - config bit 7 set disables wake driver thermal shutdown
// - config bit 6 enables precision oscillator; cleared powers it down
// - config bit 5 set drops bus pull-up, selects bit-serial mode
// - config bit 4 drives wake pin high, else internal pull-down
// - bit 3 enables supply monitor; supply below 6 V raises interrupt while supply_interrupt_source_i is set
// - config bit 2 enables low-voltage flag, read in monitor bit 3
// - config bits 1..0 select bus driver: 00 off, 10 on, others reserved
// - commands cross a two-wire serial link within 10 us
`timescale 1ns/1ns
`include "hv_indirect_defines.svh"

module hv_indirect_data_and_config
    import hv_indirect_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire mmr_req_t mmr_i,
    output logic [31:0] mmr_rdata_o,
    input wire logic link_clk_i,
    output logic link_sdata_o,
    output logic link_frame_o,
    input wire logic [7:0] hv_status_i,
    input wire logic [7:0] hv_monitor_i,
    input wire logic supply_low_i,
    input wire logic core_low_i,
    input wire logic supply_interrupt_source_i,
    output logic supply_irq_o,
    output logic thermal_shutdown_en_o,
    output logic precision_osc_en_o,
    output logic bit_serial_device_mode_o,
    output logic bus_pullup_en_o,
    output logic wake_pin_o,
    output logic wake_pin_oe_n_o,
    output logic wake_pulldown_en_o,
    output logic lin_drv_en_o,
    output logic [7:0] hv_config_one_o
);

    localparam int LAT_CYC = `HV_LATENCY_CYC;

    logic busy_q;
    logic rd_ok_q;
    logic tx_ok_q;
    logic [7:0] data_q;
    logic [3:0] tag_q;
    logic req_tgl_q;
    hv_req_t req_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_seen_q;
    logic [31:0] rdata_q;
    logic irq_s1_q;
    logic irq_s2_q;
    logic irq_q;
    logic cmd_wr;
    logic dat_wr;
    logic start;
    logic done;
    // link domain signals read by the processor domain
    logic ack_tgl_q;
    hv_rsp_t rsp_q;
    logic psm_low_q;
    assign cmd_wr = mmr_i.wr && (mmr_i.addr == `HV_CMD_ADDR);
    assign dat_wr = mmr_i.wr && (mmr_i.addr == `HV_DAT_ADDR);
    assign start = clk_en_i && cmd_wr && !busy_q;
    assign done = clk_en_i && (ack_s2_q != ack_seen_q);
    // completion toggle from link
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_seen_q <= 1'b0;
        end else if (clk_en_i) begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_seen_q <= ack_s2_q;
        end
    end

    // command launch, word held until completion
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_tgl_q <= 1'b0;
            req_q <= '0;
        end else if (start) begin
            req_q.cmd <= mmr_i.wdata[7:0];
            req_q.data <= data_q;
            req_tgl_q <= ~req_tgl_q;
        end
    end

    // busy and pass/fail
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_q <= 1'b0;
            rd_ok_q <= 1'b0;
            tx_ok_q <= 1'b0;
        end else if (done) begin
            busy_q <= 1'b0;
            rd_ok_q <= rsp_q.rd_ok;
            tx_ok_q <= rsp_q.tx_ok;
        end else if (start) begin
            busy_q <= 1'b1;
        end
    end

    // data window; returned byte wins over a same-cycle write
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_q <= 8'h00;
            tag_q <= 4'h0;
        end else if (done) begin
            data_q <= rsp_q.data;
            tag_q <= rsp_q.tag;
        end else if (clk_en_i && dat_wr) begin
            data_q <= mmr_i.wdata[`HV_DAT_VAL_MSB:`HV_DAT_VAL_LSB];
        end
    end

    // read data, one cycle after the read strobe
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (clk_en_i && mmr_i.rd) begin
            if (mmr_i.addr == `HV_DAT_ADDR) begin
                rdata_q <= {20'h00000, tag_q, data_q};
            end else if (mmr_i.addr == `HV_CMD_ADDR) begin
                rdata_q <= {29'h0000_0000, tx_ok_q, rd_ok_q, busy_q};
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end
    assign mmr_rdata_o = rdata_q;
    // supply monitor back into this domain
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_s1_q <= 1'b0;
            irq_s2_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (clk_en_i) begin
            irq_s1_q <= psm_low_q;
            irq_s2_q <= irq_s1_q;
            irq_q <= irq_s2_q && supply_interrupt_source_i;
        end
    end

    assign supply_irq_o = irq_q;

    link_state_t state_q;
    hv_req_t word_q;
    logic [15:0] shreg_q;
    logic [4:0] cnt_q;
    logic sdata_q;
    logic frame_q;
    logic [7:0] cfg0_q;
    logic [7:0] cfg1_q;
    logic lvf_q;
    logic req_s1_q;
    logic req_s2_q;
    logic req_seen_q;
    logic en_s1_q;
    logic en_s2_q;
    logic [17:0] pin_s1_q;
    logic [17:0] pin_s2_q;
    logic [7:0] sta_sync;
    logic [7:0] mon_sync;
    logic sup_sync;
    logic core_sync;
    logic lk_en;

    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            en_s1_q <= 1'b0;
            en_s2_q <= 1'b0;
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            en_s1_q <= clk_en_i;
            en_s2_q <= en_s1_q;
            pin_s1_q <= {core_low_i, supply_low_i, hv_monitor_i, hv_status_i};
            pin_s2_q <= pin_s1_q;
        end
    end
    assign lk_en = en_s2_q;
    assign sta_sync = pin_s2_q[7:0];
    assign mon_sync = pin_s2_q[15:8];
    assign sup_sync = pin_s2_q[16];
    assign core_sync = pin_s2_q[17];
    // serial shift of the command word
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= LINK_IDLE;
            req_seen_q <= 1'b0;
            word_q <= '0;
            shreg_q <= 16'h0000;
            cnt_q <= 5'h00;
            sdata_q <= 1'b0;
            frame_q <= 1'b0;
        end else if (lk_en) begin
            case (state_q)
                LINK_IDLE: begin
                    if (req_s2_q != req_seen_q) begin
                        req_seen_q <= req_s2_q;
                        word_q <= req_q;
                        shreg_q <= req_q;
                        cnt_q <= 5'h00;
                        state_q <= LINK_SHIFT;
                    end
                end
                LINK_SHIFT: begin
                    sdata_q <= shreg_q[15];
                    frame_q <= 1'b1;
                    shreg_q <= {shreg_q[14:0], 1'b0};
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'(`HV_LINK_BITS - 1)) begin
                        state_q <= LINK_EXEC;
                    end
                end
                LINK_EXEC: begin
                    frame_q <= 1'b0;
                    sdata_q <= 1'b0;
                    state_q <= LINK_IDLE;
                end
                default: begin
                    state_q <= LINK_IDLE;
                end
            endcase
        end
    end

    // indirect registers and answer
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg0_q <= `HV_CFG_RESET;
            cfg1_q <= `HV_CFG_RESET;
            rsp_q <= '0;
            ack_tgl_q <= 1'b0;
        end else if (lk_en && state_q == LINK_EXEC) begin
            rsp_q.tag <= word_q.cmd[3:0];
            rsp_q.data <= word_q.data;
            rsp_q.rd_ok <= 1'b1;
            rsp_q.tx_ok <= 1'b1;
            ack_tgl_q <= ~ack_tgl_q;
            case (word_q.cmd)
                `HV_CMD_RD_CFG0: rsp_q.data <= cfg0_q;
                `HV_CMD_RD_CFG1: rsp_q.data <= cfg1_q;
                `HV_CMD_RD_STA: rsp_q.data <= sta_sync;
                `HV_CMD_RD_MON: begin
                    rsp_q.data <= mon_sync;
                    rsp_q.data[`HV_MON_LVF_BIT] <= lvf_q;
                end
                `HV_CMD_WR_CFG0: cfg0_q <= word_q.data;
                `HV_CMD_WR_CFG1: cfg1_q <= word_q.data;
                default: begin
                    rsp_q.rd_ok <= 1'b0;
                    rsp_q.tx_ok <= 1'b0;
                end
            endcase
        end
    end

    // low-voltage flag and supply monitor
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lvf_q <= 1'b0;
            psm_low_q <= 1'b0;
        end else if (lk_en) begin
            if (cfg0_q[`HV_CFG0_LVF_EN_BIT] && core_sync) begin
                lvf_q <= 1'b1;
            end
            psm_low_q <= cfg0_q[`HV_CFG0_PSM_EN_BIT] && sup_sync;
        end
    end

    assign link_sdata_o = sdata_q;
    assign link_frame_o = frame_q;
    assign thermal_shutdown_en_o = !cfg0_q[`HV_CFG0_TSD_DIS_BIT];
    assign precision_osc_en_o = cfg0_q[`HV_CFG0_OSC_EN_BIT];
    assign bit_serial_device_mode_o = cfg0_q[`HV_CFG0_BSD_BIT];
    assign bus_pullup_en_o = !cfg0_q[`HV_CFG0_BSD_BIT];
    assign wake_pin_o = cfg0_q[`HV_CFG0_WAKE_BIT];
    assign wake_pin_oe_n_o = !cfg0_q[`HV_CFG0_WAKE_BIT];
    assign wake_pulldown_en_o = !cfg0_q[`HV_CFG0_WAKE_BIT];
    assign lin_drv_en_o =
        (cfg0_q[`HV_CFG0_LIN_MSB:`HV_CFG0_LIN_LSB] == `HV_LIN_ON);
    assign hv_config_one_o = cfg1_q;

    property p_busy_set;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        start |=> busy_q ##0 (req_q.cmd == $past(mmr_i.wdata[7:0]));
    endproperty
    a_busy_set: assert property (p_busy_set)
        else $error("busy not raised on command");
    property p_latency;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (start && clk_en_i) ##1 clk_en_i[*8] |-> ##[0:LAT_CYC] !busy_q;
    endproperty
    a_latency: assert property (p_latency)
        else $error("command not complete in time");
    property p_tag_ro;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (dat_wr && !done) |=> (tag_q == $past(tag_q));
    endproperty
    a_tag_ro: assert property (p_tag_ro)
        else $error("tag changed by software write");
    property p_tag_load;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        done |=> (tag_q == $past(rsp_q.tag)) && (data_q == $past(rsp_q.data));
    endproperty
    a_tag_load: assert property (p_tag_load)
        else $error("tag or byte not loaded on completion");
    property p_data_wr;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && dat_wr && !done) |=>
            (data_q == $past(mmr_i.wdata[7:0]));
    endproperty
    a_data_wr: assert property (p_data_wr)
        else $error("data byte not stored");
    property p_rdata;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && mmr_i.rd && mmr_i.addr == `HV_DAT_ADDR) |=>
            (mmr_rdata_o == {20'h00000, $past(tag_q), $past(data_q)});
    endproperty
    a_rdata: assert property (p_rdata)
        else $error("data window read wrong");
    property p_cfg0_wr;
        @(posedge link_clk_i) disable iff (!rst_n_i)
        (lk_en && state_q == LINK_EXEC && word_q.cmd == `HV_CMD_WR_CFG0) |=>
            (cfg0_q == $past(word_q.data));
    endproperty
    a_cfg0_wr: assert property (p_cfg0_wr)
        else $error("config zero not written");
    property p_cfg0_rd;
        @(posedge link_clk_i) disable iff (!rst_n_i)
        (lk_en && state_q == LINK_EXEC && word_q.cmd == `HV_CMD_RD_CFG0) |=>
            (rsp_q.data == $past(cfg0_q)) && (rsp_q.tag == 4'h0);
    endproperty
    a_cfg0_rd: assert property (p_cfg0_rd)
        else $error("config zero read back wrong");
    property p_lvf_sticky;
        @(posedge link_clk_i) disable iff (!rst_n_i)
        lvf_q |=> lvf_q;
    endproperty
    a_lvf_sticky: assert property (p_lvf_sticky)
        else $error("low-voltage flag lost");
    c_start: cover property (@(posedge sys_clk_i) start);
    c_done: cover property (@(posedge sys_clk_i) done && rsp_q.rd_ok);
    c_cfg0_wr: cover property (@(posedge link_clk_i)
        lk_en && state_q == LINK_EXEC && word_q.cmd == `HV_CMD_WR_CFG0);
    c_lin_on: cover property (@(posedge link_clk_i) lin_drv_en_o);
endmodule

/* File: sim/hv_die_model.sv */
`timescale 1ns/1ns
module hv_die_model (
    input wire logic link_clk_i,
    input wire logic rst_n_i,
    input wire logic link_sdata_i,
    input wire logic link_frame_i,
    output logic [7:0] cmd_o,
    output logic [7:0] data_o,
    output logic [7:0] bits_o
);
    logic [15:0] shift_q;
    logic [7:0] cnt_q;
    logic frame_q;
    // receives one command frame, msb first, cmd then data
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_q <= 16'h0000;
            cnt_q <= 8'h00;
            frame_q <= 1'b0;
            cmd_o <= 8'hff;
            data_o <= 8'hff;
            bits_o <= 8'h00;
        end else begin
            frame_q <= link_frame_i;
            if (link_frame_i) begin
                shift_q <= {shift_q[14:0], link_sdata_i};
                cnt_q <= cnt_q + 8'h01;
            end
            if (frame_q && !link_frame_i) begin
                cmd_o <= shift_q[15:8];
                data_o <= shift_q[7:0];
                bits_o <= cnt_q;
                cnt_q <= 8'h00;
            end
        end
    end
endmodule

/* File: sim/hv_indirect_data_and_config_tb.sv */
`timescale 1ns/1ns
`include "hv_indirect_defines.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("[ERR] %0t mismatch %h vs %h", $time, a, b); end end

module hv_indirect_data_and_config_tb;
    import hv_indirect_pkg::*;
    logic sys_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
    mmr_req_t mmr = '0;
    logic [31:0] rdata;
    logic [7:0] sta = 8'h00, mon = 8'h00;
    logic sup_low = 1'b0, core_low = 1'b0, src_en = 1'b0;
    logic clk_en = 1'b1;
    logic irq, tsd, osc, bit_serial_device_mode, pull, wake, wake_oe_n, wake_pd, lin;
    logic sdata, frame;
    logic [7:0] cfg1, m_cmd, m_data, m_bits;
    int err_total = 0;
    int cmp_count = 0;

    always #5 sys_clk = ~sys_clk;
    always #24 link_clk = ~link_clk;

    hv_indirect_data_and_config dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
        .clk_en_i(clk_en), .mmr_i(mmr), .mmr_rdata_o(rdata),
        .link_clk_i(link_clk), .link_sdata_o(sdata), .link_frame_o(frame),
        .hv_status_i(sta), .hv_monitor_i(mon), .supply_low_i(sup_low),
        .core_low_i(core_low), .supply_interrupt_source_i(src_en),
        .supply_irq_o(irq), .thermal_shutdown_en_o(tsd),
        .precision_osc_en_o(osc), .bit_serial_device_mode_o(bit_serial_device_mode),
        .bus_pullup_en_o(pull), .wake_pin_o(wake),
        .wake_pin_oe_n_o(wake_oe_n), .wake_pulldown_en_o(wake_pd),
        .lin_drv_en_o(lin), .hv_config_one_o(cfg1));

    hv_die_model die (.link_clk_i(link_clk), .rst_n_i(rst_n),
        .link_sdata_i(sdata), .link_frame_i(frame), .cmd_o(m_cmd),
        .data_o(m_data), .bits_o(m_bits));

    task automatic mmr_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk) mmr <= mmr_req_t'{a, 1'b1, 1'b0, d};
        @(posedge sys_clk) mmr <= '0;
    endtask

    task automatic mmr_rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge sys_clk) mmr <= mmr_req_t'{a, 1'b0, 1'b1, 32'h0};
        @(posedge sys_clk) mmr <= '0;
        @(posedge sys_clk) #1 d = rdata;
    endtask

    task automatic hv_cmd(input logic [7:0] c, input logic [7:0] wd,
                          output logic [31:0] r);
        logic [31:0] st;
        int n;
        mmr_wr(`HV_DAT_ADDR, {24'h0, wd});
        mmr_wr(`HV_CMD_ADDR, {24'h0, c});
        mmr_rd(`HV_CMD_ADDR, st);
        `CHK(st[0], 1'b1)
        n = 3;
        while (st[0] !== 1'b0 && n < `HV_LATENCY_CYC) begin
            mmr_rd(`HV_CMD_ADDR, st);
            n = n + 3;
        end
        `CHK(st[2:0], 3'b110)
        // model latches its word one link clock after the frame ends
        repeat (2) @(posedge link_clk);
        `CHK(m_cmd, c)
        `CHK(m_data, wd)
        `CHK(m_bits, 8'(`HV_LINK_BITS))
        mmr_rd(`HV_DAT_ADDR, r);
        `CHK(r[31:12], 20'h0)
        `CHK(r[11:8], c[3:0])
    endtask

    task automatic chk_cfg(input logic [7:0] c);
        `CHK(tsd, ~c[7])
        `CHK(osc, c[6])
        `CHK({bit_serial_device_mode, pull}, {c[5], ~c[5]})
        `CHK({wake, wake_oe_n, wake_pd}, {c[4], ~c[4], ~c[4]})
        `CHK(lin, c[1:0] == `HV_LIN_ON)
    endtask

    task automatic t_reset();
        logic [31:0] r;
        chk_cfg(`HV_CFG_RESET);
        `CHK(cfg1, 8'h00)
        `CHK(irq, 1'b0)
        hv_cmd(`HV_CMD_RD_CFG0, 8'h00, r);
        `CHK(r[7:0], `HV_CFG_RESET)
        $display("test reset done");
    endtask

    task automatic t_cfg0();
        logic [7:0] vals [10] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08,
                                   8'h04, 8'hfe, 8'h02, 8'h56, 8'h00};
        logic [31:0] r;
        foreach (vals[i]) begin
            hv_cmd(`HV_CMD_WR_CFG0, vals[i], r);
            `CHK(r[7:0], vals[i])
            chk_cfg(vals[i]);
            hv_cmd(`HV_CMD_RD_CFG0, 8'h00, r);
            `CHK(r[7:0], vals[i])
        end
        $display("test cfg0 done");
    endtask

    task automatic t_cfg1();
        logic [31:0] r;
        hv_cmd(`HV_CMD_WR_CFG1, 8'ha5, r);
        `CHK(cfg1, 8'ha5)
        hv_cmd(`HV_CMD_RD_CFG1, 8'h00, r);
        `CHK(r[7:0], 8'ha5)
        hv_cmd(`HV_CMD_RD_CFG0, 8'h00, r);
        `CHK(r[7:0], 8'h00)
        $display("test cfg1 done");
    endtask

    task automatic t_stamon();
        logic [31:0] r;
        sta <= 8'h3c;
        mon <= 8'hf7;
        core_low <= 1'b1;
        hv_cmd(`HV_CMD_RD_STA, 8'h00, r);
        `CHK(r[7:0], 8'h3c)
        hv_cmd(`HV_CMD_RD_MON, 8'h00, r);
        `CHK(r[7:0], 8'hf7)
        hv_cmd(`HV_CMD_WR_CFG0, 8'h04, r);
        hv_cmd(`HV_CMD_RD_MON, 8'h00, r);
        `CHK(r[7:0], 8'hff)
        core_low <= 1'b0;
        hv_cmd(`HV_CMD_RD_MON, 8'h00, r);
        `CHK(r[7:0], 8'hff)
        $display("test status monitor done");
    endtask

    task automatic t_tag();
        logic [31:0] r;
        mmr_wr(`HV_DAT_ADDR, 32'h00000f5a);
        mmr_rd(`HV_DAT_ADDR, r);
        `CHK(r[11:0], 12'h35a)
        @(posedge sys_clk) clk_en <= 1'b0;
        mmr_wr(`HV_DAT_ADDR, 32'h00000077);
        @(posedge sys_clk) clk_en <= 1'b1;
        mmr_rd(`HV_DAT_ADDR, r);
        `CHK(r[11:0], 12'h35a)
        mmr_rd(32'hffff0810, r);
        `CHK(r, 32'h0)
        $display("test tag done");
    endtask

    task automatic wait_irq(input logic v);
        int n;
        n = 0;
        while (irq !== v && n < 50) begin
            @(posedge sys_clk) #1 n++;
        end
        `CHK(irq, v)
    endtask

    task automatic t_irq();
        logic [31:0] r;
        src_en <= 1'b1;
        sup_low <= 1'b1;
        repeat (50) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        hv_cmd(`HV_CMD_WR_CFG0, 8'h08, r);
        wait_irq(1'b1);
        src_en <= 1'b0;
        wait_irq(1'b0);
        src_en <= 1'b1;
        wait_irq(1'b1);
        sup_low <= 1'b0;
        wait_irq(1'b0);
        $display("test irq done");
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #600000;
        err_total++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_cfg0();
        t_cfg1();
        t_stamon();
        t_tag();
        t_irq();
        summarize();
    end
endmodule
